/* verilog/msd_pkg.sv */
package msd_pkg;
  // program space: 12-bit counter reaches 4k bytes
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;
  localparam int WIN_BITS = 6;
  localparam int DA_W = 8;
  // data space map, byte addresses
  localparam logic [7:0] RAM_LO = 8'h00;
  localparam logic [7:0] RAM_HI = 8'h3f;
  localparam logic [7:0] WIN_LO = 8'h40;
  localparam logic [7:0] WIN_HI = 8'h7f;
  localparam logic [7:0] XYVW_LO = 8'h80;
  localparam logic [7:0] XYVW_HI = 8'h83;
  localparam logic [7:0] PORT_LO = 8'hc0;
  localparam logic [7:0] PORT_HI = 8'hcf;
  localparam logic [7:0] INTOPT_ADDR = 8'hc8;
  localparam logic [7:0] WINSEL_ADDR = 8'hc9;
  localparam logic [7:0] PERIPH_LO = 8'hd0;
  localparam logic [7:0] PERIPH_HI = 8'hd8;
  localparam logic [7:0] ACC_ADDR = 8'hff;
  // reset values
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  // decoded region codes, one-hot
  typedef enum logic [8:0] {
    MSD_R_NONE = 9'h001,
    MSD_R_RAM = 9'h002,
    MSD_R_WIN = 9'h004,
    MSD_R_XYVW = 9'h008,
    MSD_R_PORT = 9'h010,
    MSD_R_INTOPT = 9'h020,
    MSD_R_WINSEL = 9'h040,
    MSD_R_PERIPH = 9'h080,
    MSD_R_ACC = 9'h100
  } msd_region_t;
endpackage : msd_pkg

/* verilog/msd_decoder.sv */
// Operation
// - the program counter is 12 bits wide and addresses a 4K program space.
// - the return stack holds exactly six levels shared by calls and interrupt entries.
// - a 64-byte data-space window reads constants stored in program memory.
// - the data decoder maps RAM, accumulator, index, short direct, port, peripheral, option and window select.
// - with readout protection set, every external read of program memory is blocked.
// - the non-maskable interrupt is requested on a falling edge of its pin.
// - the reset pin is active low and outranks the non-maskable interrupt.
// - the programming pin is sampled during reset; high enters programming mode, ground runs normally.
// - after reset every port pin is an input with pull-up until software changes it.
// - the window occupies data addresses 40h through 7Fh.
// - a six-bit write-only block select, undefined after reset, supplies upper window address bits.
`timescale 1ns/1ps
module msd_decoder #(
  parameter int NPINS = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // core program flow
  input wire logic pc_load,
  input wire logic [11:0] pc_load_val,
  input wire logic pc_inc,
  input wire logic call_push,
  input wire logic ret_pop,
  // core data access
  input wire logic [7:0] data_addr,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic data_rd,
  // program memory read data
  input wire logic [7:0] prog_rdata,
  // external readout request and option
  input wire logic ext_rd,
  input wire logic [11:0] ext_addr,
  input wire logic readout_protect,
  // asynchronous pins
  input wire logic nmi_pin,
  input wire logic vpp_high,
  // port configuration from software
  input wire logic port_cfg_wr,
  input wire logic [NPINS-1:0] port_cfg_pullup,
  // program memory address and results
  output logic [11:0] prog_addr,
  output logic [11:0] pc,
  output logic [11:0] stack_top,
  output logic stack_full,
  output logic [8:0] region,
  output logic [7:0] win_rdata,
  output logic win_valid,
  output logic [7:0] ext_rdata,
  output logic ext_blocked,
  output logic nmi_req,
  output logic prog_mode,
  output logic [NPINS-1:0] input_with_pullup
);
  logic [11:0] pc_q, pc_d;
  logic [11:0] stk_q [msd_pkg::STACK_DEPTH];
  logic [2:0] sp_q;
  logic [5:0] rom_window_block_select_q;
  logic win_pend_q;
  logic [7:0] win_rdata_q;
  logic win_valid_q;
  logic ext_pend_q;
  logic [7:0] ext_rdata_q;
  logic ext_blocked_q;
  logic nmi_s1_q, nmi_s2_q, nmi_prev_q, nmi_req_q;
  logic vpp_s1_q, vpp_s2_q, rst_phase_q, prog_mode_q;
  logic [NPINS-1:0] ipu_q;
  logic [8:0] region_q;
  logic [11:0] prog_addr_q;
  logic [11:0] stack_top_q;
  logic stack_full_q;

  // data-space region decode
  wire in_ram = data_addr <= msd_pkg::RAM_HI;
  wire in_win = data_addr >= msd_pkg::WIN_LO && data_addr <= msd_pkg::WIN_HI;
  wire in_xyvw = data_addr >= msd_pkg::XYVW_LO && data_addr <= msd_pkg::XYVW_HI;
  wire in_port = data_addr >= msd_pkg::PORT_LO && data_addr <= msd_pkg::PORT_HI;
  wire in_per = data_addr >= msd_pkg::PERIPH_LO && data_addr <= msd_pkg::PERIPH_HI;
  wire [8:0] region_d = in_ram ? msd_pkg::MSD_R_RAM :
                        in_win ? msd_pkg::MSD_R_WIN :
                        in_xyvw ? msd_pkg::MSD_R_XYVW :
                        (data_addr == msd_pkg::INTOPT_ADDR) ? msd_pkg::MSD_R_INTOPT :
                        (data_addr == msd_pkg::WINSEL_ADDR) ? msd_pkg::MSD_R_WINSEL :
                        in_port ? msd_pkg::MSD_R_PORT :
                        in_per ? msd_pkg::MSD_R_PERIPH :
                        (data_addr == msd_pkg::ACC_ADDR) ? msd_pkg::MSD_R_ACC :
                        msd_pkg::MSD_R_NONE;
  wire win_rd = data_rd && in_win;
  wire sel_wr = data_wr && data_addr == msd_pkg::WINSEL_ADDR;
  // window address: block select over offset
  wire [11:0] win_addr = {rom_window_block_select_q, data_addr[5:0]};
  // window fetch wins the memory port; otherwise external read, then pc
  wire ext_go = ext_rd && !readout_protect && !win_rd;
  wire [11:0] paddr_d = win_rd ? win_addr : (ext_go ? ext_addr : pc_d);
  wire push_ok = call_push && sp_q != 3'(msd_pkg::STACK_DEPTH);
  wire pop_ok = ret_pop && sp_q != msd_pkg::SP_RST;
  wire [2:0] sp_m1 = sp_q - 3'h1;
  wire [11:0] pop_val = stk_q[sp_m1];
  // pointer and top entry after this edge, so the stack outputs come from flops
  wire [2:0] sp_d = push_ok ? sp_q + 3'h1 : (pop_ok ? sp_m1 : sp_q);
  wire [2:0] sp_dm1 = sp_d - 3'h1;
  wire [11:0] top_d = push_ok ? pc_q :
                      ((sp_d == msd_pkg::SP_RST) ? msd_pkg::PC_RST : stk_q[sp_dm1]);
  wire nmi_fall = nmi_prev_q && !nmi_s2_q;

  // next pc: pops restore, loads jump, pc_inc increments, else hold
  always_comb begin
    pc_d = pc_q;
    if (pop_ok) begin
      pc_d = pop_val;
    end else if (pc_load) begin
      pc_d = pc_load_val;
    end else if (pc_inc) begin
      pc_d = pc_q + 12'h001;
    end
  end

  // program counter and stack pointer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_q <= msd_pkg::PC_RST;
      sp_q <= msd_pkg::SP_RST;
      stack_top_q <= msd_pkg::PC_RST;
      stack_full_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
      stack_top_q <= top_d;
      stack_full_q <= sp_d == 3'(msd_pkg::STACK_DEPTH);
    end
  end

  // stack storage, one entry per level; push beyond six is dropped
  genvar gi;
  generate
    for (gi = 0; gi < msd_pkg::STACK_DEPTH; gi++) begin : g_stk
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          stk_q[gi] <= msd_pkg::PC_RST;
        end else if (push_ok && sp_q == 3'(gi)) begin
          stk_q[gi] <= pc_q;
        end
      end
    end
  endgenerate

  // block select has no reset: software must load it first
  always_ff @(posedge clk) begin
    if (sel_wr) begin
      rom_window_block_select_q <= data_wdata[5:0];
    end
  end

  // memory address and decode registered; read data one cycle later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_addr_q <= msd_pkg::PC_RST;
      region_q <= msd_pkg::MSD_R_NONE;
      win_pend_q <= 1'b0;
      ext_pend_q <= 1'b0;
    end else begin
      prog_addr_q <= paddr_d;
      region_q <= region_d;
      win_pend_q <= win_rd;
      ext_pend_q <= ext_go;
    end
  end

  // capture fetched bytes; protected external reads return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_rdata_q <= msd_pkg::DATA_RST;
      win_valid_q <= 1'b0;
      ext_rdata_q <= msd_pkg::DATA_RST;
      ext_blocked_q <= 1'b0;
    end else begin
      win_valid_q <= win_pend_q;
      if (win_pend_q) begin
        win_rdata_q <= prog_rdata;
      end
      ext_blocked_q <= ext_rd && readout_protect;
      ext_rdata_q <= ext_pend_q ? prog_rdata : msd_pkg::DATA_RST;
    end
  end

  // pin synchronisers and nmi falling-edge detect; reset outranks it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_prev_q <= 1'b1;
      nmi_req_q <= 1'b0;
    end else begin
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_prev_q <= nmi_s2_q;
      nmi_req_q <= nmi_fall;
    end
  end

  // programming pin synchroniser keeps running through reset, so that the
  // second stage already holds the pin level when reset is released
  always_ff @(posedge clk) begin
    vpp_s1_q <= vpp_high;
    vpp_s2_q <= vpp_s1_q;
  end

  // programming level from the second sync stage, caught at the first edge after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_phase_q <= 1'b1;
      prog_mode_q <= 1'b0;
    end else if (rst_phase_q) begin
      rst_phase_q <= 1'b0;
      prog_mode_q <= vpp_s2_q;
    end
  end

  // every pin input with pull-up until software writes a config
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ipu_q <= '1;
    end else if (port_cfg_wr) begin
      ipu_q <= port_cfg_pullup;
    end
  end

  assign prog_addr = prog_addr_q;
  assign pc = pc_q;
  assign stack_top = stack_top_q;
  assign stack_full = stack_full_q;
  assign region = region_q;
  assign win_rdata = win_rdata_q;
  assign win_valid = win_valid_q;
  assign ext_rdata = ext_rdata_q;
  assign ext_blocked = ext_blocked_q;
  assign nmi_req = nmi_req_q;
  assign prog_mode = prog_mode_q;
  assign input_with_pullup = ipu_q;

  // assertions
  a_pc_incr: assert property (@(posedge clk) disable iff (!nrst)
    (pc_inc && !pc_load && !pop_ok) |=> pc_q == $past(pc_q) + 12'h001)
    else $error("pc did not increment");
  a_stack_bound: assert property (@(posedge clk) disable iff (!nrst)
    sp_q <= 3'h6)
    else $error("stack pointer past six");
  a_push_full: assert property (@(posedge clk) disable iff (!nrst)
    (call_push && !ret_pop && sp_q == 3'h6) |=> sp_q == 3'h6)
    else $error("push on full stack moved pointer");
  a_win_addr: assert property (@(posedge clk) disable iff (!nrst)
    win_rd |=> prog_addr_q == {rom_window_block_select_q, $past(data_addr[5:0])})
    else $error("window address wrong");
  a_win_data: assert property (@(posedge clk) disable iff (!nrst)
    win_rd |-> ##2 win_valid_q)
    else $error("window data not returned");
  a_win_range: assert property (@(posedge clk) disable iff (!nrst)
    (data_rd && data_addr[7:6] == 2'b01) |=> region_q == msd_pkg::MSD_R_WIN)
    else $error("window range decode wrong");
  a_sel_decode: assert property (@(posedge clk) disable iff (!nrst)
    (data_addr == 8'hc9) |=> region_q == msd_pkg::MSD_R_WINSEL)
    else $error("select register decode wrong");
  a_prot_block: assert property (@(posedge clk) disable iff (!nrst)
    (ext_rd && readout_protect) |=> ext_blocked_q ##1 ext_rdata_q == 8'h00)
    else $error("protected read not blocked");
  a_nmi_edge: assert property (@(posedge clk) disable iff (!nrst)
    $fell(nmi_s2_q) |=> nmi_req_q)
    else $error("nmi edge missed");
  a_nmi_rise: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nmi_s2_q) |=> !nmi_req_q)
    else $error("nmi on rising edge");
  a_pullup_hold: assert property (@(posedge clk) disable iff (!nrst)
    !port_cfg_wr |=> ipu_q == $past(ipu_q))
    else $error("pull-up changed without software");
  a_prog_stable: assert property (@(posedge clk) disable iff (!nrst)
    !rst_phase_q |=> prog_mode_q == $past(prog_mode_q))
    else $error("programming mode changed after reset");
endmodule : msd_decoder

/* verification/msd_prog_mem_model.sv */
`timescale 1ns/1ps
// program memory array seen from the decoder: asynchronous read, short access time
module msd_prog_mem_model (
  // address from the decoder, 4k bytes
  input wire logic [11:0] prog_addr,
  // byte returned
  output logic [7:0] prog_rdata
);
  // show garbage while the array settles so an early sample cannot match by luck
  always @(prog_addr) begin
    prog_rdata = ~prog_rdata;
    #2 prog_rdata = prog_addr[7:0] ^ {prog_addr[11:6], 2'b10};
  end
endmodule : msd_prog_mem_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk, nrst, pc_load, pc_inc, call_push, ret_pop, data_wr, data_rd, ext_rd;
  logic readout_protect, nmi_pin, vpp_high, port_cfg_wr, stack_full, win_valid;
  logic ext_blocked, nmi_req, prog_mode;
  logic [11:0] pc_load_val, ext_addr, port_cfg_pullup, prog_addr, pc, stack_top;
  logic [11:0] input_with_pullup;
  logic [7:0] data_addr, data_wdata, prog_rdata, win_rdata, ext_rdata, off;
  logic [8:0] region;
  logic [5:0] sel;
  logic [7:0] exp_q[$];
  int num_errors, checked, seed, n;
  logic [7:0] ra [11] = '{8'h00, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hc0, 8'hc8, 8'hc9,
    8'hd8, 8'he0, 8'hff};
  logic [8:0] rx [11] = '{msd_pkg::MSD_R_RAM, msd_pkg::MSD_R_RAM, msd_pkg::MSD_R_WIN,
    msd_pkg::MSD_R_WIN, msd_pkg::MSD_R_XYVW, msd_pkg::MSD_R_PORT, msd_pkg::MSD_R_INTOPT,
    msd_pkg::MSD_R_WINSEL, msd_pkg::MSD_R_PERIPH, msd_pkg::MSD_R_NONE, msd_pkg::MSD_R_ACC};

  msd_decoder #(.NPINS(12)) u_msd_decoder (.clk(clk), .nrst(nrst), .pc_load(pc_load),
    .pc_load_val(pc_load_val), .pc_inc(pc_inc), .call_push(call_push), .ret_pop(ret_pop),
    .data_addr(data_addr), .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd),
    .prog_rdata(prog_rdata), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .readout_protect(readout_protect), .nmi_pin(nmi_pin), .vpp_high(vpp_high),
    .port_cfg_wr(port_cfg_wr), .port_cfg_pullup(port_cfg_pullup), .prog_addr(prog_addr),
    .pc(pc), .stack_top(stack_top), .stack_full(stack_full), .region(region),
    .win_rdata(win_rdata), .win_valid(win_valid), .ext_rdata(ext_rdata),
    .ext_blocked(ext_blocked), .nmi_req(nmi_req), .prog_mode(prog_mode),
    .input_with_pullup(input_with_pullup));
  msd_prog_mem_model u_msd_prog_mem_model (.prog_addr(prog_addr), .prog_rdata(prog_rdata));

  // 100 MHz
  always #5 clk = ~clk;

  // expected array content, worked out independently of the model
  function automatic logic [7:0] mem_byte(input logic [11:0] a);
    return a[7:0] ^ {a[11:6], 2'b10};
  endfunction : mem_byte

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // vpp held steady across the whole reset so the latch sees a stable level;
  // the nmi pin falls inside reset and is high again at release
  task automatic do_reset(input logic vpp);
    @(negedge clk);
    nrst = 0;
    vpp_high = vpp;
    nmi_pin = 0;
    repeat (2) @(negedge clk);
    nmi_pin = 1;
    nrst = 1;
  endtask : do_reset

  // window results are matched in order against the notes left by the driver
  always @(negedge clk) begin
    if (win_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(12'h1, 12'h0, "unexpected window byte");
      else chk(12'(win_rdata), 12'(exp_q.pop_front()), "window byte");
    end
  end

  initial begin
    clk = 0; nrst = 0; seed = 32'h3225; num_errors = 0; checked = 0;
    {pc_load, pc_inc, call_push, ret_pop, data_wr, data_rd, ext_rd} = '0;
    {readout_protect, vpp_high, port_cfg_wr} = '0;
    nmi_pin = 1; pc_load_val = '0; ext_addr = '0; port_cfg_pullup = '0;
    data_addr = '0; data_wdata = '0;
    do_reset(1'b0);
    chk(pc, msd_pkg::PC_RST, "pc after reset");
    chk(12'(region), 12'(msd_pkg::MSD_R_NONE), "region after reset");
    chk(input_with_pullup, 12'hfff, "pullups after reset");
    // block select, then back-to-back window reads including both ends
    @(negedge clk);
    sel = 6'($random(seed));
    data_wr = 1; data_addr = msd_pkg::WINSEL_ADDR; data_wdata = {2'b00, sel};
    @(negedge clk);
    data_wr = 0;
    chk(12'(prog_mode), 12'h0, "normal mode");
    for (int i = 0; i < 8; i++) begin
      off = (i == 0) ? 8'h40 : (i == 1) ? 8'h7f : 8'h40 | 8'($random(seed) & 8'h3f);
      data_rd = 1; data_addr = off;
      exp_q.push_back(mem_byte({sel, off[5:0]}));
      @(negedge clk);
    end
    data_rd = 0;
    repeat (3) @(negedge clk);
    chk(12'(exp_q.size()), 12'h0, "window reads lost");
    // region decode, one cycle behind the address
    for (int i = 0; i < 11; i++) begin
      data_addr = ra[i];
      @(negedge clk);
      chk(12'(region), 12'(rx[i]), "region");
    end
    // 12-bit counter wraps, six-level stack refuses the seventh push
    pc_load = 1; pc_load_val = 12'hfff;
    @(negedge clk);
    pc_load = 0; pc_inc = 1;
    @(negedge clk);
    pc_inc = 0;
    chk(pc, 12'h000, "pc wrap");
    for (int i = 0; i < 7; i++) begin
      call_push = 1; pc_load = 1; pc_load_val = 12'(i + 1);
      @(negedge clk);
    end
    call_push = 0; pc_load = 0;
    chk(12'(stack_full), 12'h1, "stack full");
    chk(stack_top, 12'h005, "stack top full");
    ret_pop = 1;
    @(negedge clk);
    chk(pc, 12'h005, "pop");
    chk(12'(stack_full), 12'h0, "stack not full");
    repeat (6) @(negedge clk);
    ret_pop = 0;
    chk(pc, 12'h000, "pop to empty");
    chk(stack_top, 12'h000, "empty top");
    // external readout protected, then open
    readout_protect = 1; ext_rd = 1; ext_addr = 12'($random(seed));
    @(negedge clk);
    ext_rd = 0;
    chk(12'(ext_blocked), 12'h1, "blocked flag");
    @(negedge clk);
    chk(12'(ext_rdata), 12'h0, "blocked data");
    readout_protect = 0; ext_rd = 1;
    @(negedge clk);
    ext_rd = 0;
    chk(12'(ext_blocked), 12'h0, "open flag");
    @(negedge clk);
    chk(12'(ext_rdata), 12'(mem_byte(ext_addr)), "open data");
    // falling edge on the non-maskable pin, bounded wait
    nmi_pin = 0;
    for (n = 0; n < 6 && nmi_req !== 1'b1; n++) @(negedge clk);
    chk(12'(nmi_req), 12'h1, "nmi request");
    @(negedge clk);
    chk(12'(nmi_req), 12'h0, "nmi one pulse");
    nmi_pin = 1;
    repeat (4) begin
      @(negedge clk);
      chk(12'(nmi_req), 12'h0, "nmi on rising pin");
    end
    port_cfg_pullup = 12'($random(seed)); port_cfg_wr = 1;
    @(negedge clk);
    port_cfg_wr = 0;
    chk(input_with_pullup, port_cfg_pullup, "pullup config");
    // reset with programming level; a pin fall inside reset must not reach the core
    do_reset(1'b1);
    chk(input_with_pullup, 12'hfff, "pullups restored");
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      chk(12'(nmi_req), 12'h0, "nmi under reset");
    end
    chk(12'(prog_mode), 12'h1, "programming mode");
    do_reset(1'b0);
    repeat (2) @(negedge clk);
    chk(12'(prog_mode), 12'h0, "normal again");
    tally_and_finish();
  end
endmodule : tb
